/* File: hdl/hcrb_cfg.svh */
/*
  Offsets, field positions, reset values and delay counts of the
  host control register bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef HCRB_CFG_SVH
`define HCRB_CFG_SVH

`define HCRB_OFF_IRQ_ROUTE        8'h90
`define HCRB_OFF_CPU_RESET        8'h94
`define HCRB_OFF_REVISION         8'h98
`define HCRB_OFF_NVM_DATA         8'h9C
`define HCRB_OFF_DMA1_SRC         8'hA0
`define HCRB_OFF_DMA2_SRC         8'hA4
`define HCRB_OFF_DMA1_DST         8'hA8
`define HCRB_OFF_DMA2_DST         8'hAC

`define HCRB_IRQ_ROUTE_RESET      32'h00004000
`define HCRB_PTR_RESET            32'h00000000
`define HCRB_REVISION_CODE        32'h0000A5A5 // Arbitrary code

// Writable routing fields; reserved bits hold their value
`define HCRB_IRQ_RW_MASK          32'h2C307FFF
`define HCRB_BIT_PCI_DMA_A        12
`define HCRB_LINE0_LSB            0
`define HCRB_LINE1_LSB            4
`define HCRB_LINE2_LSB            8

`define HCRB_BIT_COLD             0
`define HCRB_BIT_WARM             1
`define HCRB_BIT_DISABLE          2
`define HCRB_LED_LSB              8
`define HCRB_BIT_CTX_INIT         14
`define HCRB_BIT_RAM_INIT         15
`define HCRB_WIN_LSB              16

`define HCRB_WARM_DELAY_CYC       17'd16384
`define HCRB_COLD_DELAY_CYC       17'd65536
`define HCRB_DEST_STEP            32'h00000010

`endif

/* File: hdl/hcrb_pkg.sv */
/*
  Types shared by the host control register bank.
  Assumes nothing from the constants header; its one-hot state codes are written here.
*/
package hcrb_pkg;
  typedef enum logic [2:0] {
    HCRB_RST_HELD = 3'b001,
    HCRB_RST_WAIT = 3'b010,
    HCRB_RST_FREE = 3'b100
  } hcrb_rst_state_t;
endpackage

/* File: hdl/hcrb_reset_delay.sv */
/*
  One delayed-release reset output with abort on re-assertion.
  Assumes hold and release requests are synchronous to mclk.
*/
`timescale 1ns/100ps
`include "hcrb_cfg.svh"

module hcrb_reset_delay (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        hold,
  input  wire logic        start,
  input  wire logic [16:0] delay,
  output logic             reset_out_n,
  output logic             releasing
);
  hcrb_pkg::hcrb_rst_state_t state_reg;
  hcrb_pkg::hcrb_rst_state_t state_next;
  logic [16:0]               cnt_reg;
  logic [16:0]               cnt_next;
  wire                       cnt_done;

  assign cnt_done = (cnt_reg == 17'd1);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      hcrb_pkg::HCRB_RST_HELD:
      begin
        if (start && !hold)
        begin
          state_next = hcrb_pkg::HCRB_RST_WAIT;
          cnt_next   = delay;
        end
      end
      hcrb_pkg::HCRB_RST_WAIT:
      begin
        if (hold)
          state_next = hcrb_pkg::HCRB_RST_HELD;
        else if (start)
          cnt_next = delay;
        else if (cnt_done)
          state_next = hcrb_pkg::HCRB_RST_FREE;
        else
          cnt_next = cnt_reg - 17'd1;
      end
      hcrb_pkg::HCRB_RST_FREE:
      begin
        // A repeated one while released leaves the output high
        if (hold)
          state_next = hcrb_pkg::HCRB_RST_HELD;
      end
      default:
        state_next = hcrb_pkg::HCRB_RST_HELD;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= hcrb_pkg::HCRB_RST_HELD;
      cnt_reg     <= 17'd0;
      reset_out_n <= 1'b0;
      releasing   <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      reset_out_n <= (state_next == hcrb_pkg::HCRB_RST_FREE);
      releasing   <= (state_next == hcrb_pkg::HCRB_RST_WAIT);
    end
  end
endmodule // hcrb_reset_delay

/* File: hdl/hcrb_top.sv */
/*
  Host control register bank: interrupt routing, embedded CPU reset
  sequencing, indicator pins, revision, EEPROM user data, DMA list
  pointers.
  Assumes a simple synchronous host register port on mclk, inputs from
  other mclk logic except the interrupt sources, treated as pins.
*/
`timescale 1ns/100ps
`include "hcrb_cfg.svh"

module hcrb_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_addr,
  input  wire logic [31:0] host_wdata,
  output logic [31:0]      host_rdata,
  input  wire logic        protected_mode,
  input  wire logic        irq_engine,
  input  wire logic        irq_dma_pair_a,
  input  wire logic        irq_dma_pair_b,
  input  wire logic        irq_soft,
  input  wire logic        nvm_load,
  input  wire logic [15:0] nvm_word_25,
  input  wire logic [15:0] nvm_word_26,
  input  wire logic [15:0] sdram_window_size,
  input  wire logic        shared_ram_init_done,
  input  wire logic        context_ram_init_done,
  input  wire logic        cpu_bus_busy,
  input  wire logic        dma1_dest_advance,
  input  wire logic        dma2_dest_advance,
  input  wire logic        dma1_src_load,
  input  wire logic        dma2_src_load,
  input  wire logic [31:0] dma_src_load_value,
  output logic             cpu_irq_line0,
  output logic             cpu_irq_line1,
  output logic             cpu_irq_line2,
  output logic             pci_irq_dma_pair_a,
  output logic [2:0]       led_n,
  output logic             cpu_interface_disable,
  output logic             cpu_warm_reset_n,
  output logic             cpu_cold_reset_n,
  output logic [31:0]      dma1_source_list_ptr,
  output logic [31:0]      dma2_source_list_ptr,
  output logic [31:0]      dma1_dest_list_ptr,
  output logic [31:0]      dma2_dest_list_ptr
);
  logic [31:0] irq_route_config_reg;
  logic [2:0]  led_reg;
  logic        disable_req_reg;
  logic        warm_bit_reg;
  logic        cold_bit_reg;
  logic [1:0]  unlock_seen_reg;
  logic        route_unlocked_reg;
  logic [31:0] nvm_user_data_reg;
  logic [3:0]  irq_meta_reg;
  logic [3:0]  irq_sync_reg;
  logic        cold_wait_reg;
  logic        cold_release_seen_reg;
  logic        cold_n;
  logic        cold_releasing;
  logic        warm_n;

  wire [3:0]  irq_src;
  wire        wr_route;
  wire        wr_reset;
  wire        wr_d1s;
  wire        wr_d2s;
  wire        wr_d1d;
  wire        wr_d2d;
  wire        wr_warm0;
  wire        wr_warm1;
  wire        wr_cold0;
  wire        wr_cold1;
  wire        cold_rise;
  wire        cold_done;
  wire        warm_hold;
  wire        warm_start;
  wire        lock_open;
  wire [31:0] reset_read;
  wire [31:0] rdata_next;
  wire [31:0] route_next;
  wire        line0_next;
  wire        line1_next;
  wire        line2_next;

  // Interrupt sources: bit 3 engine, 2 pair b, 1 pair a, 0 soft
  assign irq_src = irq_sync_reg;

  // Write decode; protected mode closes the guarded offsets
  assign wr_route = host_wr && host_addr == `HCRB_OFF_IRQ_ROUTE
                    && route_unlocked_reg && !protected_mode;
  assign wr_reset = host_wr && host_addr == `HCRB_OFF_CPU_RESET;
  assign wr_d1s   = host_wr && host_addr == `HCRB_OFF_DMA1_SRC;
  assign wr_d2s   = host_wr && host_addr == `HCRB_OFF_DMA2_SRC
                    && !protected_mode;
  assign wr_d1d   = host_wr && host_addr == `HCRB_OFF_DMA1_DST
                    && !protected_mode;
  assign wr_d2d   = host_wr && host_addr == `HCRB_OFF_DMA2_DST
                    && !protected_mode;

  assign wr_warm0 = wr_reset && !host_wdata[`HCRB_BIT_WARM];
  assign wr_warm1 = wr_reset && host_wdata[`HCRB_BIT_WARM];
  assign wr_cold0 = wr_reset && !host_wdata[`HCRB_BIT_COLD];
  assign wr_cold1 = wr_reset && host_wdata[`HCRB_BIT_COLD];
  assign cold_rise = wr_cold1 && !cold_bit_reg;
  assign lock_open = unlock_seen_reg[0] && unlock_seen_reg[1];

  // Warm reset stays held while the cold delay runs; the hold drops in
  // the cycle the cold release is seen, so the warm delay starts then
  assign cold_done  = cold_wait_reg && cold_n && cold_release_seen_reg;
  assign warm_hold  = wr_warm0 || (cold_wait_reg && !cold_done) || cold_rise
                      || (wr_cold0 && cold_wait_reg);
  assign warm_start = (wr_warm1 && !cold_wait_reg && !cold_rise)
                      || (cold_done && warm_bit_reg);

  assign route_next = (irq_route_config_reg & ~`HCRB_IRQ_RW_MASK)
                      | (host_wdata & `HCRB_IRQ_RW_MASK);

  // One routing term per source and interrupt line
  genvar gi;
  wire [3:0] hit0;
  wire [3:0] hit1;
  wire [3:0] hit2;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_route
      assign hit0[gi] = irq_src[gi]
        & irq_route_config_reg[`HCRB_LINE0_LSB + gi];
      assign hit1[gi] = irq_src[gi]
        & irq_route_config_reg[`HCRB_LINE1_LSB + gi];
      assign hit2[gi] = irq_src[gi]
        & irq_route_config_reg[`HCRB_LINE2_LSB + gi];
    end
  endgenerate
  assign line0_next = |hit0;
  assign line1_next = |hit1;
  assign line2_next = |hit2;

  assign reset_read = {sdram_window_size,
                       shared_ram_init_done,
                       context_ram_init_done,
                       3'h0, led_reg, 5'h00,
                       disable_req_reg, warm_bit_reg, cold_bit_reg};

  // Read mux; guarded offsets read zero in protected mode
  assign rdata_next =
    (host_addr == `HCRB_OFF_IRQ_ROUTE && !protected_mode)
      ? irq_route_config_reg :
    (host_addr == `HCRB_OFF_CPU_RESET) ? reset_read :
    (host_addr == `HCRB_OFF_REVISION) ? `HCRB_REVISION_CODE :
    (host_addr == `HCRB_OFF_NVM_DATA && !protected_mode)
      ? nvm_user_data_reg :
    (host_addr == `HCRB_OFF_DMA1_SRC) ? dma1_source_list_ptr :
    (host_addr == `HCRB_OFF_DMA2_SRC && !protected_mode)
      ? dma2_source_list_ptr :
    (host_addr == `HCRB_OFF_DMA1_DST && !protected_mode)
      ? dma1_dest_list_ptr :
    (host_addr == `HCRB_OFF_DMA2_DST && !protected_mode)
      ? dma2_dest_list_ptr : 32'h00000000;

  // Each reset pin has its own delayed-release sequencer
  hcrb_reset_delay u_cold (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .hold        (wr_cold0),
    .start       (wr_cold1),
    .delay       (`HCRB_COLD_DELAY_CYC),
    .reset_out_n (cold_n),
    .releasing   (cold_releasing)
  );

  hcrb_reset_delay u_warm (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .hold        (warm_hold),
    .start       (warm_start),
    .delay       (`HCRB_WARM_DELAY_CYC),
    .reset_out_n (warm_n),
    .releasing   ()
  );

  // Two-stage synchronisers for the interrupt source pins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_meta_reg <= 4'h0;
      irq_sync_reg <= 4'h0;
    end
    else
    begin
      irq_meta_reg <= {irq_engine, irq_dma_pair_b, irq_dma_pair_a, irq_soft};
      irq_sync_reg <= irq_meta_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_route_config_reg <= `HCRB_IRQ_ROUTE_RESET;
      unlock_seen_reg      <= 2'h0;
      route_unlocked_reg   <= 1'b0;
    end
    else
    begin
      if (wr_route)
        irq_route_config_reg <= route_next;
      // Unlock bits are sticky and need not arrive in one write
      if (wr_reset)
        unlock_seen_reg <= unlock_seen_reg | host_wdata[1:0];
      if (lock_open)
        route_unlocked_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_reg               <= 3'h0;
      disable_req_reg       <= 1'b0;
      warm_bit_reg          <= 1'b0;
      cold_bit_reg          <= 1'b0;
      cold_wait_reg         <= 1'b0;
      cold_release_seen_reg <= 1'b0;
    end
    else
    begin
      if (wr_reset)
      begin
        led_reg         <= host_wdata[`HCRB_LED_LSB +: 3];
        disable_req_reg <= host_wdata[`HCRB_BIT_DISABLE];
        warm_bit_reg    <= host_wdata[`HCRB_BIT_WARM];
        cold_bit_reg    <= host_wdata[`HCRB_BIT_COLD];
      end
      if (cold_rise)
        cold_wait_reg <= 1'b1;
      else if (wr_cold0 || cold_done)
        cold_wait_reg <= 1'b0;
      cold_release_seen_reg <= cold_releasing;
    end
  end

  // User data captured when the EEPROM loader presents its words
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      nvm_user_data_reg <= 32'h00000000;
    else if (nvm_load)
      nvm_user_data_reg <= {nvm_word_26, nvm_word_25};
  end

  // List pointers; the DMA side may reload or advance them
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dma1_source_list_ptr <= `HCRB_PTR_RESET;
      dma2_source_list_ptr <= `HCRB_PTR_RESET;
      dma1_dest_list_ptr   <= `HCRB_PTR_RESET;
      dma2_dest_list_ptr   <= `HCRB_PTR_RESET;
    end
    else
    begin
      if (dma1_src_load)
        dma1_source_list_ptr <= dma_src_load_value;
      else if (wr_d1s)
        dma1_source_list_ptr <= host_wdata;
      if (dma2_src_load)
        dma2_source_list_ptr <= dma_src_load_value;
      else if (wr_d2s)
        dma2_source_list_ptr <= host_wdata;
      if (dma1_dest_advance)
        dma1_dest_list_ptr <= dma1_dest_list_ptr
                              + `HCRB_DEST_STEP;
      else if (wr_d1d)
        dma1_dest_list_ptr <= host_wdata;
      if (dma2_dest_advance)
        dma2_dest_list_ptr <= dma2_dest_list_ptr
                              + `HCRB_DEST_STEP;
      else if (wr_d2d)
        dma2_dest_list_ptr <= host_wdata;
    end
  end

  // Every top output except the four DMA list pointers leaves through this register stage
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_rdata            <= 32'h00000000;
      cpu_irq_line0         <= 1'b0;
      cpu_irq_line1         <= 1'b0;
      cpu_irq_line2         <= 1'b0;
      pci_irq_dma_pair_a    <= 1'b0;
      led_n                 <= 3'h7;
      cpu_interface_disable <= 1'b0;
      cpu_warm_reset_n      <= 1'b0;
      cpu_cold_reset_n      <= 1'b0;
    end
    else
    begin
      host_rdata    <= host_rd ? rdata_next : 32'h00000000;
      cpu_irq_line0 <= line0_next;
      cpu_irq_line1 <= line1_next;
      cpu_irq_line2 <= line2_next;
      pci_irq_dma_pair_a <= irq_src[1]
        & irq_route_config_reg[`HCRB_BIT_PCI_DMA_A];
      led_n <= ~led_reg;
      if (!disable_req_reg)
        cpu_interface_disable <= 1'b0;
      else if (!cpu_bus_busy)
        cpu_interface_disable <= 1'b1;
      cpu_warm_reset_n <= warm_n;
      cpu_cold_reset_n <= cold_n;
    end
  end
endmodule // hcrb_top

/* File: sim/hcrb_far_model.sv */
/*
  Far-side model: embedded CPU bus and DMA unit one.
  Assumes go pulses from the bench, synchronous to mclk.
*/
`timescale 1ns/100ps

module hcrb_far_model #(
  parameter int TXN = 8
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic cpu_interface_disable,
  output logic      cpu_bus_busy,
  output logic      dest_advance
);
  int cnt;

  // A transaction holds the bus TXN cycles, then retires a dest command
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      cnt          <= 0;
      dest_advance <= 1'b0;
    end
    else
    begin
      dest_advance <= (cnt == 1);
      if (cnt != 0)
        cnt <= cnt - 1;
      else if (go && !cpu_interface_disable)
        cnt <= TXN;
    end

  assign cpu_bus_busy = (cnt != 0);
endmodule // hcrb_far_model

/* File: sim/hcrb_checker.sv */
/*
  Port checker of the host control register bank.
  Assumes it is bound to hcrb_top and sees only its ports.
*/
`timescale 1ns/100ps
`include "hcrb_cfg.svh"

module hcrb_checker (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [7:0]  host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic        protected_mode,
  input wire logic        irq_engine,
  input wire logic        irq_dma_pair_a,
  input wire logic        irq_dma_pair_b,
  input wire logic        irq_soft,
  input wire logic [15:0] sdram_window_size,
  input wire logic        shared_ram_init_done,
  input wire logic        context_ram_init_done,
  input wire logic        cpu_bus_busy,
  input wire logic        cpu_irq_line0,
  input wire logic        cpu_irq_line1,
  input wire logic        cpu_irq_line2,
  input wire logic        pci_irq_dma_pair_a,
  input wire logic        cpu_interface_disable,
  input wire logic        cpu_warm_reset_n,
  input wire logic        cpu_cold_reset_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [16:0] hi_cnt;
  wire         rd_rst  = host_rd && host_addr == `HCRB_OFF_CPU_RESET;
  wire         wr_rst  = host_wr && host_addr == `HCRB_OFF_CPU_RESET;
  wire         any_src = irq_engine | irq_dma_pair_a | irq_dma_pair_b
                         | irq_soft;
  wire         any_out = cpu_irq_line0 | cpu_irq_line1 | cpu_irq_line2
                         | pci_irq_dma_pair_a;

  // Cycles since the cold reset output was released
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      hi_cnt <= 17'h0;
    else if (!cpu_cold_reset_n)
      hi_cnt <= 17'h0;
    else if (hi_cnt != 17'h1FFFF)
      hi_cnt <= hi_cnt + 17'h1;

  property p_prot_zero;
    host_rd && protected_mode && host_addr == `HCRB_OFF_DMA2_SRC
      |=> host_rdata == 32'h0;
  endproperty
  a_prot_zero: assert property (p_prot_zero)
    else $error("protected read not zero");
  property p_warm_on; wr_rst && !host_wdata[1] |-> ##2 !cpu_warm_reset_n;
  endproperty
  a_warm_on: assert property (p_warm_on)
    else $error("warm reset not asserted");
  property p_cold_on; wr_rst && !host_wdata[0] |-> ##2 !cpu_cold_reset_n;
  endproperty
  a_cold_on: assert property (p_cold_on)
    else $error("cold reset not asserted");
  property p_warm_hold; $rose(cpu_warm_reset_n) |-> hi_cnt >= 17'h3FF0;
  endproperty
  a_warm_hold: assert property (p_warm_hold)
    else $error("warm released early after cold");
  property p_disable; $rose(cpu_interface_disable) |-> !$past(cpu_bus_busy);
  endproperty
  a_disable: assert property (p_disable)
    else $error("interface disabled mid transaction");
  property p_quiet; !any_src [*4] |-> !any_out; endproperty
  a_quiet: assert property (p_quiet)
    else $error("interrupt line without source");
  property p_pci; pci_irq_dma_pair_a |-> $past(irq_dma_pair_a, 3); endproperty
  a_pci: assert property (p_pci)
    else $error("host interrupt without pair a source");
  property p_rev;
    host_rd && host_addr == `HCRB_OFF_REVISION
      |=> host_rdata == `HCRB_REVISION_CODE;
  endproperty
  a_rev: assert property (p_rev)
    else $error("revision code wrong");
  property p_status;
    rd_rst |=> host_rdata[31:14] == {$past(sdram_window_size),
      $past(shared_ram_init_done), $past(context_ram_init_done)};
  endproperty
  a_status: assert property (p_status)
    else $error("status fields wrong");

  c_warm_free: cover property ($rose(cpu_warm_reset_n));
  c_prot_rd: cover property (host_rd && protected_mode);
  c_disable: cover property ($rose(cpu_interface_disable));
endmodule // hcrb_checker

bind hcrb_top hcrb_checker i_hcrb_checker (.*);

/* File: sim/hcrb_tb_top.sv */
/*
  Self-checking bench of the host control register bank.
  Assumes design, checker and far-side model are compiled first.
*/
`timescale 1ns/100ps
`include "hcrb_cfg.svh"

module hcrb_tb_top;
  logic        mclk, rst_n, host_wr, host_rd, protected_mode, go, nvm_load;
  logic        irq_engine, irq_dma_pair_a, irq_dma_pair_b, irq_soft;
  logic        shared_ram_init_done, context_ram_init_done, cpu_bus_busy;
  logic        dma1_dest_advance, dma2_dest_advance;
  logic        dma1_src_load, dma2_src_load, cpu_interface_disable;
  logic        cpu_irq_line0, cpu_irq_line1, cpu_irq_line2;
  logic        pci_irq_dma_pair_a, cpu_warm_reset_n, cpu_cold_reset_n;
  logic [2:0]  led_n;
  logic [3:0]  src;
  logic [7:0]  host_addr;
  logic [15:0] nvm_word_25, nvm_word_26, sdram_window_size;
  logic [31:0] host_wdata, host_rdata, dma_src_load_value, seed, cfg_m;
  logic [31:0] dma1_source_list_ptr, dma2_source_list_ptr;
  logic [31:0] dma1_dest_list_ptr, dma2_dest_list_ptr;
  logic [31:0] ptr_m [4];
  logic [7:0]  pa [5] = '{8'h90, 8'h9C, 8'hA4, 8'hA8, 8'hAC};
  int          miscompares = 0;
  int          n_tests = 0;

  hcrb_top i_hcrb_top (.*);
  hcrb_far_model i_hcrb_far_model (.mclk, .rst_n, .go,
    .cpu_interface_disable, .cpu_bus_busy, .dest_advance(dma1_dest_advance));

  always #10 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_addr  = a;
    host_wdata = d;
    pulse(host_wr);
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host_addr = a;
    pulse(host_rd);
    chk(host_rdata, e);
    cyc(1);
  endtask

  task automatic meas(input bit w, input int lo);
    int n;
    n = 0;
    while ((w ? cpu_warm_reset_n : cpu_cold_reset_n) !== 1'b1 && n < lo + 9)
    begin
      cyc(1);
      n++;
    end
    chk(32'(n >= lo - 2 && n <= lo + 4), 32'h1);
  endtask

  task automatic fin(input string s);
    $display("%0t test %s done", $time, s);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Expected run is about 82350 cycles
  initial
  begin
    #(20 * 90000);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    {mclk, rst_n, host_wr, host_rd, protected_mode, go, nvm_load} = '0;
    {irq_engine, irq_dma_pair_a, irq_dma_pair_b, irq_soft} = '0;
    {dma2_dest_advance, dma1_src_load, dma2_src_load} = '0;
    {host_addr, host_wdata, dma_src_load_value} = '0;
    {nvm_word_25, nvm_word_26, sdram_window_size} = '0;
    shared_ram_init_done  = 1'b1;
    context_ram_init_done = 1'b0;
    seed  = 32'h6688A27F;
    cfg_m = `HCRB_IRQ_ROUTE_RESET;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd(8'h90, cfg_m);
    wr(8'h90, 32'hFFFFFFFF);
    rd(8'h90, cfg_m);
    wr(8'h98, 32'h0);
    rd(8'h98, `HCRB_REVISION_CODE);
    rd(8'h80, 32'h0);
    seed = lfsr(seed);
    {nvm_word_26, nvm_word_25} = seed;
    sdram_window_size = seed[23:8];
    pulse(nvm_load);
    rd(8'h9C, seed);
    rd(8'h94, {sdram_window_size, 16'h8000});
    chk({29'h0, led_n}, 32'h7);
    fin("identity");
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      ptr_m[i] = {seed[31:2], 2'b00};
      wr(8'hA0 + 8'(4 * i), ptr_m[i]);
    end
    pulse(go);
    cyc(12);
    ptr_m[2] += `HCRB_DEST_STEP;
    pulse(dma2_dest_advance);
    ptr_m[3] += `HCRB_DEST_STEP;
    seed = lfsr(seed);
    dma_src_load_value = seed;
    pulse(dma1_src_load);
    ptr_m[0] = seed;
    dma_src_load_value = ~seed;
    pulse(dma2_src_load);
    ptr_m[1] = ~seed;
    for (int i = 0; i < 4; i++)
      rd(8'hA0 + 8'(4 * i), ptr_m[i]);
    chk(dma1_dest_list_ptr, ptr_m[2]);
    chk(dma2_source_list_ptr, ptr_m[1]);
    fin("pointers");
    protected_mode = 1'b1;
    foreach (pa[i])
    begin
      seed = lfsr(seed);
      wr(pa[i], {seed[31:2], 2'b00});
      rd(pa[i], 32'h0);
    end
    ptr_m[0] = {seed[29:0], 2'b00};
    wr(8'hA0, ptr_m[0]);
    rd(8'hA0, ptr_m[0]);
    protected_mode = 1'b0;
    for (int i = 0; i < 4; i++)
      rd(8'hA0 + 8'(4 * i), ptr_m[i]);
    rd(8'h90, cfg_m);
    fin("protected");
    pulse(go);
    wr(8'h94, 32'h504);
    chk({31'h0, cpu_interface_disable}, 32'h0);
    for (int n = 0; n < 12 && cpu_interface_disable !== 1'b1; n++)
      cyc(1);
    chk({cpu_bus_busy, cpu_interface_disable}, 2'b01);
    chk({29'h0, led_n}, 32'h2);
    cyc(50);
    fin("disable");
    wr(8'h94, 32'h505);
    cyc(100);
    chk({31'h0, cpu_cold_reset_n}, 32'h0);
    wr(8'h94, 32'h504);
    chk({31'h0, cpu_cold_reset_n}, 32'h0);
    wr(8'h94, 32'h507);
    meas(1'b0, 65536);
    chk({31'h0, cpu_warm_reset_n}, 32'h0);
    meas(1'b1, 16384);
    shared_ram_init_done  = 1'b0;
    context_ram_init_done = 1'b1;
    rd(8'h94, {sdram_window_size, 16'h4507});
    wr(8'h94, 32'h505);
    chk({cpu_cold_reset_n, cpu_warm_reset_n}, 32'h2);
    wr(8'h94, 32'h507);
    cyc(100);
    chk({31'h0, cpu_warm_reset_n}, 32'h0);
    wr(8'h94, 32'h505);
    chk({31'h0, cpu_warm_reset_n}, 32'h0);
    fin("resets");
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      wr(8'h90, seed);
      cfg_m = (cfg_m & ~`HCRB_IRQ_RW_MASK) | (seed & `HCRB_IRQ_RW_MASK);
      rd(8'h90, cfg_m);
      seed = lfsr(seed);
      src = seed[3:0];
      {irq_engine, irq_dma_pair_b, irq_dma_pair_a, irq_soft} = src;
      cyc(4);
      chk({pci_irq_dma_pair_a, cpu_irq_line2, cpu_irq_line1, cpu_irq_line0},
          {cfg_m[12] & src[1], |(cfg_m[11:8] & src), |(cfg_m[7:4] & src),
           |(cfg_m[3:0] & src)});
    end
    src = 4'h0;
    {irq_engine, irq_dma_pair_b, irq_dma_pair_a, irq_soft} = src;
    cyc(5);
    fin("routing");
    end_of_test();
  end
endmodule // hcrb_tb_top
